/* File: logic/ovh_pkg.sv */
// shared constants for the overhead insertion pair
package ovh_pkg;
  // register offsets on the 8-bit register port
  localparam logic [15:0] OFF_INSERT_CTRL = 16'h1902;
  localparam logic [15:0] OFF_E1_VALUE = 16'h1943;
  localparam logic [15:0] OFF_TRACE_VALUE = 16'h194B;
  localparam logic [15:0] OFF_TRACE_CTRL = 16'h194F;
  localparam logic [15:0] OFF_STATUS = 16'h19FF;
  localparam logic [15:0] OFF_TRACE_BUF = 16'h1B00;
  localparam int TRACE_BUF_DEPTH = 64;

  // field positions
  localparam int ORDERWIRE_SRC_BIT = 4;
  localparam logic [7:0] INSERT_CTRL_RW_MASK = 8'h3F;
  localparam int TRACE_SRC_LSB = 0;
  localparam int TRACE_LEN_LSB = 2;

  // reset values
  localparam logic [7:0] INSERT_CTRL_RESET = 8'h00;
  localparam logic [7:0] E1_VALUE_RESET = 8'h00;
  localparam logic [7:0] TRACE_VALUE_RESET = 8'h00;
  localparam logic [3:0] TRACE_CTRL_RESET = 4'h0;

  // trace source selection
  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_BUFFER = 2'h1;
  localparam logic [1:0] SRC_SOFTWARE = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  localparam logic [7:0] FIXED_TRACE_BYTE = 8'h01;

  // trace message lengths as last buffer index
  localparam logic [5:0] LEN1_LAST = 6'h00;
  localparam logic [5:0] LEN16_LAST = 6'h0F;
  localparam logic [5:0] LEN64_LAST = 6'h3F;

  // link timing
  localparam int SYS_CLK_MHZ = 50;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS * SYS_CLK_MHZ) / 2000;
  localparam int WAIT_PERIODS = 16;
  localparam int SLOT_BITS = 8;
  localparam int FIRST_BIT_PERIOD = WAIT_PERIODS + 1;
  localparam int LAST_BIT_PERIOD = FIRST_BIT_PERIOD + SLOT_BITS - 1;
  localparam int FRAME_PERIODS = 64;
endpackage

/* File: logic/ovh_if.sv */
// serial overhead port between the device and the external insertion logic
`timescale 1ns/1ps
interface ovh_if;
  logic ovh_clk_out;
  logic ovh_slot_enable;
  logic ovh_frame_mark;
  logic ovh_serial_in;
  logic path_ovh_serial_in;
  logic ovh_insert_req;

  modport dev (
    output ovh_clk_out,
    output ovh_slot_enable,
    output ovh_frame_mark,
    input ovh_serial_in,
    input path_ovh_serial_in,
    input ovh_insert_req
  );

  modport ext (
    input ovh_clk_out,
    input ovh_slot_enable,
    input ovh_frame_mark,
    output ovh_serial_in,
    output path_ovh_serial_in,
    output ovh_insert_req
  );
endinterface

/* File: logic/ovh_pair_buf.sv */
// small ring buffer with valid and ready on both sides
`timescale 1ns/1ps
module ovh_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("depth must be a power of two, two or more");
    end
  endgenerate

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty straight from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = store_r[rd_ptr_r];

  // storage is written only on a push
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: logic/ovh_device_end.sv */
// transmit trace and orderwire byte selection with serial overhead port
// What this block does
// - length field: 00=1, 01=16, else 64 bytes
// - source 01 takes trace byte from buffer
// - source 10 sends software trace value register
// - source 11 takes trace byte from serial port
// - external logic samples enable and frame each rise
// - external waits 16 periods, then drives MSB
// - device latches bit on following falling edge
// - remaining seven bits follow on seven falls
// - trace byte is third overhead byte slot
// - insert request not needed for external source
// - control bit 4 set sends software orderwire
// - source 00 sends constant 0x01
// - software writes first message byte lowest location
// - bit 4 clear takes orderwire from path port
`timescale 1ns/1ps
module ovh_device_end #(
  parameter int HALF_PERIOD = ovh_pkg::LINK_HALF_CYCLES,
  parameter int FRAME_PERIODS = ovh_pkg::FRAME_PERIODS
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  ovh_if.dev link,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic frame_valid,
  input wire logic frame_ready,
  output logic [7:0] frame_trace,
  output logic [7:0] frame_orderwire,
  output logic insert_req_seen
);
  localparam int HW = (HALF_PERIOD > 1) ? $clog2(HALF_PERIOD) : 1;

  generate
    if (HALF_PERIOD < 4 || HALF_PERIOD > 255) begin : g_bad_half
      $error("half period must be 4 to 255 system clocks");
    end
    if (FRAME_PERIODS < ovh_pkg::LAST_BIT_PERIOD + 2 || FRAME_PERIODS > 256) begin : g_bad_frame
      $error("frame must hold the trace slot and fit 256 periods");
    end
  endgenerate

  // last buffer index for a given length code
  function automatic logic [5:0] trace_last(input logic [1:0] len_sel);
    unique case (len_sel)
      2'h0: trace_last = ovh_pkg::LEN1_LAST;
      2'h1: trace_last = ovh_pkg::LEN16_LAST;
      2'h2, 2'h3: trace_last = ovh_pkg::LEN64_LAST;
    endcase
  endfunction

  // software visible state
  logic [7:0] insert_ctrl_r;
  logic [7:0] orderwire_byte_value_r;
  logic [7:0] trace_byte_value_r;
  logic [3:0] trace_ctrl_r;
  logic [7:0] trace_mem [ovh_pkg::TRACE_BUF_DEPTH];
  logic [5:0] trace_ptr_r;

  // link side state
  logic [HW-1:0] half_cnt_r;
  logic lclk_r;
  logic [7:0] period_r;
  logic mark_r;
  logic ser_s1_r;
  logic ser_s2_r;
  logic path_s1_r;
  logic path_s2_r;
  logic ins_s1_r;
  logic ins_s2_r;
  logic [7:0] trace_sh_r;
  logic [7:0] orderwire_sh_r;

  // field views
  wire [1:0] trace_source_sel = trace_ctrl_r[ovh_pkg::TRACE_SRC_LSB +: 2];
  wire [1:0] trace_length_sel = trace_ctrl_r[ovh_pkg::TRACE_LEN_LSB +: 2];
  wire orderwire_src_software = insert_ctrl_r[ovh_pkg::ORDERWIRE_SRC_BIT];
  wire [5:0] trace_last_idx = trace_last(trace_length_sel);

  // address decode
  wire hit_insert_ctrl = (reg_addr == ovh_pkg::OFF_INSERT_CTRL);
  wire hit_e1 = (reg_addr == ovh_pkg::OFF_E1_VALUE);
  wire hit_trace_val = (reg_addr == ovh_pkg::OFF_TRACE_VALUE);
  wire hit_trace_ctrl = (reg_addr == ovh_pkg::OFF_TRACE_CTRL);
  wire hit_status = (reg_addr == ovh_pkg::OFF_STATUS);
  wire hit_buf = (reg_addr[15:6] == ovh_pkg::OFF_TRACE_BUF[15:6]);
  wire [5:0] buf_idx = reg_addr[5:0];

  // read data selection, unmapped addresses read zero
  wire [7:0] rd_sel =
    hit_insert_ctrl ? (insert_ctrl_r & ovh_pkg::INSERT_CTRL_RW_MASK) :
    hit_e1 ? orderwire_byte_value_r :
    hit_trace_val ? trace_byte_value_r :
    hit_trace_ctrl ? {4'h0, trace_ctrl_r} :
    hit_status ? {ins_s2_r, 1'b0, trace_ptr_r} :
    hit_buf ? trace_mem[buf_idx] : 8'h00;

  // control registers written from the register port
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      insert_ctrl_r <= ovh_pkg::INSERT_CTRL_RESET;
      orderwire_byte_value_r <= ovh_pkg::E1_VALUE_RESET;
      trace_byte_value_r <= ovh_pkg::TRACE_VALUE_RESET;
      trace_ctrl_r <= ovh_pkg::TRACE_CTRL_RESET;
    end else if (reg_wr) begin
      if (hit_insert_ctrl) insert_ctrl_r <= reg_wdata & ovh_pkg::INSERT_CTRL_RW_MASK;
      if (hit_e1) orderwire_byte_value_r <= reg_wdata;
      if (hit_trace_val) trace_byte_value_r <= reg_wdata;
      if (hit_trace_ctrl) trace_ctrl_r <= reg_wdata[3:0];
    end
  end

  // message buffer, first message byte lives at index zero
  always_ff @(posedge sys_clk) begin
    if (reg_wr && hit_buf) begin
      trace_mem[buf_idx] <= reg_wdata;
    end
  end

  // registered read answer one cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_sel;
    end
  end

  // link clock divider and period timing
  wire half_tick = (half_cnt_r == HW'(HALF_PERIOD - 1));
  wire fall_ev = half_tick && lclk_r;
  wire at_frame_end = (period_r == 8'(FRAME_PERIODS - 1));
  wire buf_in_ready;
  wire advance = fall_ev && !(at_frame_end && !buf_in_ready);
  wire in_slot = (period_r >= 8'(ovh_pkg::FIRST_BIT_PERIOD)) && (period_r <= 8'(ovh_pkg::LAST_BIT_PERIOD));
  wire slot_done = fall_ev && (period_r == 8'(ovh_pkg::LAST_BIT_PERIOD));

  // the frame waits at its last period while the output buffer is full
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_r <= '0;
      lclk_r <= 1'b0;
      period_r <= 8'(FRAME_PERIODS - 1);
      mark_r <= 1'b0;
    end else begin
      half_cnt_r <= half_tick ? '0 : half_cnt_r + 1'b1;
      if (half_tick) lclk_r <= !lclk_r;
      if (advance) begin
        period_r <= at_frame_end ? 8'h00 : period_r + 8'h01;
        mark_r <= at_frame_end;
      end
    end
  end

  assign link.ovh_clk_out = lclk_r;
  assign link.ovh_slot_enable = mark_r;
  assign link.ovh_frame_mark = mark_r;

  // two-flop synchronisers for the incoming pins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_s1_r <= 1'b0;
      ser_s2_r <= 1'b0;
      path_s1_r <= 1'b0;
      path_s2_r <= 1'b0;
      ins_s1_r <= 1'b0;
      ins_s2_r <= 1'b0;
    end else begin
      ser_s1_r <= link.ovh_serial_in;
      ser_s2_r <= ser_s1_r;
      path_s1_r <= link.path_ovh_serial_in;
      path_s2_r <= path_s1_r;
      ins_s1_r <= link.ovh_insert_req;
      ins_s2_r <= ins_s1_r;
    end
  end

  assign insert_req_seen = ins_s2_r;

  // bits are taken at the end of the high phase after each rise, msb first
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trace_sh_r <= 8'h00;
      orderwire_sh_r <= 8'h00;
    end else if (fall_ev && in_slot) begin
      trace_sh_r <= {trace_sh_r[6:0], ser_s2_r};
      orderwire_sh_r <= {orderwire_sh_r[6:0], path_s2_r};
    end
  end

  // complete serial bytes including the bit taken in this cycle
  wire [7:0] ext_trace = {trace_sh_r[6:0], ser_s2_r};
  wire [7:0] ext_orderwire = {orderwire_sh_r[6:0], path_s2_r};

  // external capture depends only on the source field, never the request pin
  wire [7:0] trace_out =
    (trace_source_sel == ovh_pkg::SRC_FIXED) ? ovh_pkg::FIXED_TRACE_BYTE :
    (trace_source_sel == ovh_pkg::SRC_BUFFER) ? trace_mem[trace_ptr_r] :
    (trace_source_sel == ovh_pkg::SRC_SOFTWARE) ? trace_byte_value_r :
    ext_trace;

  wire [7:0] orderwire_out = orderwire_src_software ? orderwire_byte_value_r :
    ext_orderwire;

  // message pointer steps once per frame in buffer mode
  wire ptr_wrap = (trace_ptr_r >= trace_last_idx);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trace_ptr_r <= 6'h00;
    end else if (slot_done && trace_source_sel == ovh_pkg::SRC_BUFFER) begin
      trace_ptr_r <= ptr_wrap ? 6'h00 : trace_ptr_r + 6'h01;
    end
  end

  // each frame's byte pair goes through the buffer; space was checked at frame start
  ovh_pair_buf #(
    .WIDTH(16),
    .DEPTH(2)
  ) i_ovh_pair_buf (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(slot_done),
    .in_ready(buf_in_ready),
    .in_data({trace_out, orderwire_out}),
    .out_valid(frame_valid),
    .out_ready(frame_ready),
    .out_data({frame_trace, frame_orderwire})
  );
endmodule

/* File: logic/ovh_host_end.sv */
// external insertion logic that shifts trace and orderwire bytes into the device
`timescale 1ns/1ps
module ovh_host_end (
  input wire logic sys_clk,
  input wire logic arst_n,
  ovh_if.ext link,
  input wire logic [7:0] trace_byte,
  input wire logic [7:0] orderwire_byte,
  input wire logic insert_req,
  output logic byte_taken,
  output logic slot_busy
);
  typedef enum logic [1:0] {MONITOR, WAIT_SLOT, SHIFT} host_state_e;

  host_state_e state_r;
  logic clk_s1_r;
  logic clk_s2_r;
  logic clk_s3_r;
  logic en_s1_r;
  logic en_s2_r;
  logic fr_s1_r;
  logic fr_s2_r;
  logic [4:0] wait_cnt_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] trace_sh_r;
  logic [7:0] orderwire_sh_r;
  logic ser_r;
  logic path_r;
  logic ins_r;

  // edges of the synchronised link clock
  wire rise = clk_s2_r && !clk_s3_r;
  wire fall = !clk_s2_r && clk_s3_r;
  wire frame_seen = rise && en_s2_r && fr_s2_r;
  wire wait_done = rise && (wait_cnt_r == 5'(ovh_pkg::WAIT_PERIODS - 1));
  wire last_bit = fall && (bit_cnt_r == 3'(ovh_pkg::SLOT_BITS - 1));

  // synchronisers for the device outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      fr_s1_r <= 1'b0;
      fr_s2_r <= 1'b0;
    end else begin
      clk_s1_r <= link.ovh_clk_out;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      en_s1_r <= link.ovh_slot_enable;
      en_s2_r <= en_s1_r;
      fr_s1_r <= link.ovh_frame_mark;
      fr_s2_r <= fr_s1_r;
    end
  end

  // monitor, wait sixteen periods, then shift eight bits on falls
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= MONITOR;
      wait_cnt_r <= 5'h00;
      bit_cnt_r <= 3'h0;
      trace_sh_r <= 8'h00;
      orderwire_sh_r <= 8'h00;
      ser_r <= 1'b0;
      path_r <= 1'b0;
      byte_taken <= 1'b0;
    end else begin
      byte_taken <= 1'b0;
      unique case (state_r)
        MONITOR: begin
          if (frame_seen) begin
            state_r <= WAIT_SLOT;
            wait_cnt_r <= 5'h00;
            trace_sh_r <= trace_byte;
            orderwire_sh_r <= orderwire_byte;
            byte_taken <= 1'b1;
          end
        end
        WAIT_SLOT: begin
          if (wait_done) begin
            state_r <= SHIFT;
            bit_cnt_r <= 3'h0;
          end else if (rise) begin
            wait_cnt_r <= wait_cnt_r + 5'h01;
          end
        end
        SHIFT: begin
          if (fall) begin
            ser_r <= trace_sh_r[7];
            path_r <= orderwire_sh_r[7];
            trace_sh_r <= {trace_sh_r[6:0], 1'b0};
            orderwire_sh_r <= {orderwire_sh_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (last_bit) state_r <= MONITOR;
          end
        end
      endcase
    end
  end

  // the request pin is optional for external trace sourcing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ins_r <= 1'b0;
    end else begin
      ins_r <= insert_req;
    end
  end

  assign slot_busy = (state_r != MONITOR);
  assign link.ovh_serial_in = ser_r;
  assign link.path_ovh_serial_in = path_r;
  assign link.ovh_insert_req = ins_r;
endmodule

/* File: verification/ovh_link_assertions.sv */
// timing checks on the serial overhead port between the two ends
`timescale 1ns/1ps
module ovh_link_assertions #(
  parameter int FRAME_PERIODS = 64
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ovh_clk_out,
  input wire logic ovh_slot_enable,
  input wire logic ovh_frame_mark,
  input wire logic ovh_serial_in,
  input wire logic path_ovh_serial_in
);
  localparam int FRAME_CYC = FRAME_PERIODS * 8;
  logic mark_q_r;
  logic [9:0] since_r;
  logic [9:0] since_nxt;
  // cycles since the last frame mark rose, saturating
  wire mark_rise = ovh_frame_mark && !mark_q_r;
  wire sat = &since_r;
  wire in_slot = since_r >= 10'h088 && since_r <= 10'h0CC && since_r[2:0] != 3'h0 && since_r[2:0] != 3'h7;
  assign since_nxt = mark_rise ? 10'h001 : (sat ? since_r : since_r + 10'h001);
  // track mark and slot position
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mark_q_r <= 1'b0;
      since_r <= 10'h3FF;
    end else begin
      mark_q_r <= ovh_frame_mark;
      since_r <= since_nxt;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_mark_period;
    ovh_frame_mark [*8] ##1 !ovh_frame_mark;
  endsequence
  sequence s_clk_high;
    ovh_clk_out [*4] ##1 !ovh_clk_out;
  endsequence
  sequence s_clk_low;
    !ovh_clk_out [*4] ##1 ovh_clk_out;
  endsequence
  AST_MARK_PAIR:
    assert property (ovh_slot_enable == ovh_frame_mark) else $error("enable and frame differ");
  AST_MARK_ON_LOW_CLK:
    assert property ($rose(ovh_frame_mark) |-> !ovh_clk_out) else $error("mark rose while clock high");
  AST_MARK_WIDTH:
    assert property ($rose(ovh_frame_mark) |-> s_mark_period) else $error("mark not one link period");
  AST_CLK_HIGH:
    assert property ($rose(ovh_clk_out) |-> s_clk_high) else $error("link clock high phase wrong");
  AST_CLK_LOW:
    assert property ($fell(ovh_clk_out) |-> s_clk_low) else $error("link clock low phase wrong");
  AST_MARK_SPACING:
    assert property (mark_rise |-> since_r >= FRAME_CYC) else $error("frame marks too close");
  AST_TRACE_SLOT:
    assert property ($changed(ovh_serial_in) |-> in_slot) else $error("trace bit outside its slot");
  AST_PATH_SLOT:
    assert property ($changed(path_ovh_serial_in) |-> in_slot) else $error("orderwire bit outside slot");
endmodule

/* File: verification/tb_tx_section_trace_e1_insert.sv */
// self-checking bench for the device end and the external insertion end
`timescale 1ns/1ps
module tb_tx_section_trace_e1_insert;
  localparam int FP = 26;
  // cycles the host stays busy: sixteen waited periods, half a period to the fall, seven more bit periods
  localparam int BUSY_CYC = (2 * ovh_pkg::WAIT_PERIODS + 1 + 2 * (ovh_pkg::SLOT_BITS - 1)) * ovh_pkg::LINK_HALF_CYCLES;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid, frame_valid, insert_req_seen, byte_taken, slot_busy;
  logic frame_ready = 1'b0;
  logic [7:0] frame_trace, frame_orderwire;
  logic [7:0] trace_byte = 8'hA5;
  logic [7:0] orderwire_byte = 8'h3C;
  logic insert_req = 1'b0;
  int fail_count = 0;
  int cmp_count = 0;
  ovh_if i_ovh_if ();
  ovh_device_end #(.FRAME_PERIODS(FP)) i_ovh_device_end (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(i_ovh_if.dev), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_trace(frame_trace), .frame_orderwire(frame_orderwire), .insert_req_seen(insert_req_seen));
  ovh_host_end i_ovh_host_end (.sys_clk(sys_clk), .arst_n(arst_n), .link(i_ovh_if.ext),
    .trace_byte(trace_byte), .orderwire_byte(orderwire_byte), .insert_req(insert_req),
    .byte_taken(byte_taken), .slot_busy(slot_busy));
  ovh_link_assertions #(.FRAME_PERIODS(FP)) i_ovh_link_assertions (.sys_clk(sys_clk), .arst_n(arst_n),
    .ovh_clk_out(i_ovh_if.ovh_clk_out), .ovh_slot_enable(i_ovh_if.ovh_slot_enable),
    .ovh_frame_mark(i_ovh_if.ovh_frame_mark), .ovh_serial_in(i_ovh_if.ovh_serial_in),
    .path_ovh_serial_in(i_ovh_if.path_ovh_serial_in));
  // 50 MHz system clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // compare one byte and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // register write, one strobe cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // register read, waits a bounded time for the answer
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 3) begin
      @(negedge sys_clk);
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
  // take one frame pair from the output stream
  task automatic take(output logic [7:0] t, output logic [7:0] o);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (frame_valid !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    t = frame_trace;
    o = frame_orderwire;
    frame_ready = 1'b1;
    @(negedge sys_clk);
    frame_ready = 1'b0;
  endtask
  // discard frames built before a setting changed
  task automatic flush();
    logic [7:0] t, o;
    repeat (3) take(t, o);
  endtask
  // reset values, read-only bits, unmapped place, buffer load
  task automatic test_regs();
    logic [7:0] d;
    logic [15:0] ra[4];
    ra = '{ovh_pkg::OFF_INSERT_CTRL, ovh_pkg::OFF_E1_VALUE, ovh_pkg::OFF_TRACE_VALUE, ovh_pkg::OFF_TRACE_CTRL};
    foreach (ra[i]) begin
      rd(ra[i], d);
      check(d, 8'h00, "reset value");
      wr(ra[i], 8'hFF);
    end
    rd(ovh_pkg::OFF_INSERT_CTRL, d);
    check(d, 8'h3F, "insert control bits");
    rd(ovh_pkg::OFF_TRACE_CTRL, d);
    check(d, 8'h0F, "trace control bits");
    wr(16'h1234, 8'h55);
    rd(16'h1234, d);
    check(d, 8'h00, "unmapped read");
    wr(ovh_pkg::OFF_E1_VALUE, 8'h77);
    wr(ovh_pkg::OFF_TRACE_VALUE, 8'h5E);
    rd(ovh_pkg::OFF_E1_VALUE, d);
    check(d, 8'h77, "orderwire value");
    rd(ovh_pkg::OFF_TRACE_VALUE, d);
    check(d, 8'h5E, "trace value");
    for (int i = 0; i < 64; i++) begin
      wr(ovh_pkg::OFF_TRACE_BUF + 16'(i), 8'h80 + 8'(i));
    end
    rd(ovh_pkg::OFF_TRACE_BUF + 16'h003F, d);
    check(d, 8'hBF, "last buffer byte");
    rd(ovh_pkg::OFF_TRACE_BUF, d);
    check(d, 8'h80, "first buffer byte");
    $display("test regs done");
  endtask
  // every trace source, software orderwire with odd sources and path orderwire with even
  task automatic test_sources();
    logic [7:0] t, o, d;
    logic [7:0] exp_t[4];
    exp_t = '{ovh_pkg::FIXED_TRACE_BYTE, 8'h80, 8'h5E, 8'hA5};
    for (int s = 0; s < 4; s++) begin
      wr(ovh_pkg::OFF_INSERT_CTRL, s[0] ? 8'h10 : 8'h00);
      wr(ovh_pkg::OFF_TRACE_CTRL, {6'h00, s[1:0]});
      flush();
      take(t, o);
      check(t, exp_t[s], "trace byte");
      check(o, s[0] ? 8'h77 : 8'h3C, "orderwire byte");
    end
    insert_req = 1'b1;
    take(t, o);
    check(t, 8'hA5, "external with request");
    rd(ovh_pkg::OFF_STATUS, d);
    check(d & 8'h80, 8'h80, "request seen");
    check({7'h00, insert_req_seen}, 8'h01, "request pin seen");
    insert_req = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({7'h00, insert_req_seen}, 8'h00, "request pin released");
    rd(ovh_pkg::OFF_STATUS, d);
    check(d & 8'h80, 8'h00, "request cleared");
    $display("test sources done");
  endtask
  // host end latches its bytes on a mark and stays busy for exactly the sixteen-period wait plus its slot
  task automatic test_host();
    int n, busy;
    n = 0;
    busy = 0;
    frame_ready = 1'b1;
    @(negedge sys_clk);
    while (byte_taken !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    check({7'h00, byte_taken}, 8'h01, "byte taken pulse");
    check({7'h00, slot_busy}, 8'h01, "host busy after mark");
    while (slot_busy === 1'b1 && busy < 600) begin
      @(negedge sys_clk);
      busy++;
    end
    check({7'h00, byte_taken}, 8'h00, "byte taken is a pulse");
    check({7'h00, slot_busy}, 8'h00, "host back to monitoring");
    check(8'(busy), 8'(BUSY_CYC), "host slot length");
    frame_ready = 1'b0;
    $display("test host done");
  endtask
  // buffer bytes step per frame and wrap at each length
  task automatic test_len();
    logic [7:0] t, o;
    int last, idx;
    for (int l = 0; l < 4; l++) begin
      last = (l == 0) ? 0 : ((l == 1) ? 15 : 63);
      wr(ovh_pkg::OFF_TRACE_CTRL, {4'h0, l[1:0], 2'h1});
      flush();
      take(t, o);
      idx = int'(t) - 128;
      for (int k = 0; k < last + 2; k++) begin
        idx = (idx >= last) ? 0 : idx + 1;
        take(t, o);
        check(t, 8'h80 + 8'(idx), "buffer sequence");
      end
    end
    $display("test lengths done");
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    test_regs();
    test_sources();
    test_host();
    test_len();
    conclude();
  end
endmodule
